// ---- hdl/tcd_pkg.sv ----
// Shared constants and types of the two-channel transfer controller
// Assumes an APB slave port on pclk and a simple one-master memory bus port
package tcd_pkg;
   localparam int NUM_CH = 2;
   localparam int CH_STRIDE = 32'h20;
   // Per-channel register offsets (byte addresses inside a channel window); OFF_CH1 is the channel 1 window base
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_SRC = 8'h08;
   localparam logic [7:0] OFF_DST = 8'h0C;
   localparam logic [7:0] OFF_CNT = 8'h10;
   localparam logic [7:0] OFF_CH1 = 8'h20;
   localparam logic [7:0] OFF_MASK = 8'h1C;
   // Control register fields
   localparam int CTL_START = 0;
   localparam int CTL_REQ_LO = 1;
   localparam int CTL_BW_LO = 3;
   localparam int CTL_SIZE_LO = 5;
   localparam int CTL_SINGLE = 7;
   localparam int CTL_SRC_INC = 8;
   localparam int CTL_DST_INC = 9;
   localparam int CTL_SA_WRITE = 10;
   localparam int CTL_ACK_DST = 11;
   localparam int CTL_ONCHIP = 12;
   localparam logic [12:0] CTL_RESET = 13'h0000;
   // Status bits
   localparam int ST_DONE = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_CFG_ERR = 2;
   localparam int ST_BUS_ERR = 3;
   // Request sources
   localparam logic [1:0] REQ_INT = 2'h0;
   localparam logic [1:0] REQ_BURST = 2'h1;
   localparam logic [1:0] REQ_STEAL = 2'h2;
   // Operand sizes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   // Bandwidth window
   localparam logic [9:0] BW_WINDOW_LAST = 10'h3FF;
   localparam logic [9:0] BW_QUARTER = 10'h100;
   // Fixed bus access time in pclk cycles
   localparam logic [1:0] BUS_CYCLES = 2'h2;
   typedef struct packed {
      logic req;
      logic write;
      logic [31:0] addr;
      logic [1:0] size;
      logic [31:0] wdata;
   } tcd_bus_req_t;
   typedef struct packed {
      logic done;
      logic err;
      logic [31:0] rdata;
   } tcd_bus_rsp_t;
endpackage

// ---- hdl/tcd_req_sync.sv ----
// Request pin conditioning for one channel
// Assumes an asynchronous active-low request pin
module tcd_req_sync
   import tcd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req_n_pin,
   output logic level,
   output logic fall
);
   logic s1_q, s2_q, s3_q;
   // Two-stage synchroniser then edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= req_n_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign level = ~s2_q;
   assign fall = s3_q & ~s2_q;
endmodule

// ---- hdl/tcd_dma.sv ----
// Two-channel direct memory transfer controller with APB registers
// Assumes one memory bus master port and async request pins per channel
// Behaviour
// - Two independent identical programmable channels
// - Separate request, acknowledge, completion per channel
// - Only one channel owns bus
// - Byte, word and long operand sizes
// - Single-address: 32-bit address, 32-bit data
// - Single-address starts only on external request
// - Single-address: device supplies data, we address
// - Dual-address: 32-bit address, 16-bit data
// - Dual-address started internally or externally
// - Dual-address: read source, then write destination
// - Unpack to lane by address; long operands move only 16 bits
// - Internal request bandwidth share programmable
// - Burst and cycle steal with handshake
// - Two 32-bit byte counters
// - Four pointers, increment or hold
// - Accept every bus termination kind
// - Module accesses take two clocks
// - Status records outcome at finish
// - No single-address toward on-chip peripherals
// - Burst level, steal falling-edge request
// - Acknowledge marks operand being transferred
// - Completion line marks final transfer
//
// The address map and the APB interface to the registers were chosen for this implementation.
module tcd_dma
   import tcd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output tcd_bus_req_t bus_req,
   input wire tcd_bus_rsp_t bus_rsp,
   input wire logic [1:0] transfer_request_n,
   output logic [1:0] transfer_ack_n,
   input wire logic [1:0] done_n_in,
   output logic [1:0] done_n_out,
   output logic [1:0] done_n_oe_n
);
   // ------------------------------------------------------------
   // Types and shared state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_READ = 4'h2,
      ST_WRITE = 4'h4,
      ST_FINISH = 4'h8
   } tcd_state_t;

   tcd_state_t state_q;
   logic owner_q;
   logic [1:0] grant;
   logic [1:0] want;
   logic [16:0] hold_q;
   logic last_q;
   logic ack_q;
   logic [1:0] ext_done;
   logic [1:0] req_lvl, req_fall;
   logic [12:0] ctrl_q [NUM_CH];
   logic [3:0] stat_q [NUM_CH];
   logic [31:0] src_q [NUM_CH];
   logic [31:0] dst_q [NUM_CH];
   logic [31:0] cnt_q [NUM_CH];
   logic [1:0] steal_pend_q;
   logic [9:0] win_q;
   logic [9:0] used_q [NUM_CH];
   logic acc;
   logic ch_sel;
   logic [7:0] reg_off;

   // APB access decode
   assign acc = psel & penable;
   assign ch_sel = paddr[5];
   assign reg_off = paddr & ~OFF_CH1;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ------------------------------------------------------------
   // Per-channel request conditioning and registers
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         logic [1:0] rmode;
         logic [1:0] bw;
         logic started;
         logic budget_ok;
         logic wr_here;
         logic op_end;
         logic [31:0] step;
         assign rmode = ctrl_q[gi][CTL_REQ_LO +: 2];
         assign bw = ctrl_q[gi][CTL_BW_LO +: 2];
         assign started = ctrl_q[gi][CTL_START] & stat_q[gi][ST_BUSY];
         assign wr_here = acc & pwrite & (ch_sel == 1'(gi));
         assign op_end = (state_q == ST_FINISH) & (owner_q == 1'(gi));
         assign step = (ctrl_q[gi][CTL_SIZE_LO +: 2] == SZ_LONG) ? 32'h4 :
                       (ctrl_q[gi][CTL_SIZE_LO +: 2] == SZ_WORD) ? 32'h2 : 32'h1;

         // Request pin sampled on two flops
         tcd_req_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .req_n_pin(transfer_request_n[gi]),
            .level(req_lvl[gi]),
            .fall(req_fall[gi])
         );

         // Done line synchronised for the completion input
         logic d1_q, d2_q;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               d1_q <= 1'b1;
               d2_q <= 1'b1;
            end else begin
               d1_q <= done_n_in[gi];
               d2_q <= d1_q;
            end
         end
         assign ext_done[gi] = ~d2_q;

         // Bandwidth budget in 1024-clock window; 0 means full rate
         assign budget_ok = (bw == 2'h0) | (used_q[gi] < 10'(bw * BW_QUARTER));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               used_q[gi] <= 10'h000;
            end else if (win_q == BW_WINDOW_LAST) begin
               used_q[gi] <= 10'h000;
            end else if (state_q != ST_IDLE && owner_q == 1'(gi)) begin
               used_q[gi] <= used_q[gi] + 10'h001;
            end
         end

         // Cycle steal: one pending request, ignored while already pending
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               steal_pend_q[gi] <= 1'b0;
            end else if (req_fall[gi] && rmode == REQ_STEAL && started) begin
               steal_pend_q[gi] <= 1'b1;
            end else if (op_end) begin
               steal_pend_q[gi] <= 1'b0;
            end
         end

         // Request to bus arbiter; single-address needs external request
         always_comb begin
            case (rmode)
               REQ_INT: want[gi] = started & budget_ok & ~ctrl_q[gi][CTL_SINGLE];
               REQ_BURST: want[gi] = started & req_lvl[gi];
               REQ_STEAL: want[gi] = started & steal_pend_q[gi];
               default: want[gi] = 1'b0;
            endcase
         end

         // Control register with start and configuration
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl_q[gi] <= CTL_RESET;
            end else if (wr_here && reg_off == OFF_CTRL) begin
               ctrl_q[gi] <= pwdata[12:0];
            end else if (op_end && (last_q || hold_q[16])) begin
               ctrl_q[gi][CTL_START] <= 1'b0;
            end
         end

         // Status: outcome at finish, set wins over write-one clear
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat_q[gi] <= 4'h0;
            end else begin
               if (wr_here && reg_off == OFF_STAT) begin
                  stat_q[gi][ST_DONE] <= stat_q[gi][ST_DONE] & ~pwdata[ST_DONE];
                  stat_q[gi][ST_CFG_ERR] <= stat_q[gi][ST_CFG_ERR] & ~pwdata[ST_CFG_ERR];
                  stat_q[gi][ST_BUS_ERR] <= stat_q[gi][ST_BUS_ERR] & ~pwdata[ST_BUS_ERR];
               end
               if (wr_here && reg_off == OFF_CTRL && pwdata[CTL_START]) begin
                  if (pwdata[CTL_SINGLE] &&
                      (pwdata[CTL_ONCHIP] || pwdata[CTL_REQ_LO +: 2] == REQ_INT)) begin
                     stat_q[gi][ST_CFG_ERR] <= 1'b1;
                  end else begin
                     stat_q[gi][ST_BUSY] <= 1'b1;
                  end
               end
               if (op_end && (last_q || hold_q[16])) begin
                  stat_q[gi][ST_BUSY] <= 1'b0;
                  stat_q[gi][ST_DONE] <= 1'b1;
                  stat_q[gi][ST_BUS_ERR] <= stat_q[gi][ST_BUS_ERR] | hold_q[16];
               end
            end
         end

         // Pointers and byte counter
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               src_q[gi] <= 32'h0;
               dst_q[gi] <= 32'h0;
               cnt_q[gi] <= 32'h0;
            end else if (wr_here && reg_off == OFF_SRC) begin
               src_q[gi] <= pwdata;
            end else if (wr_here && reg_off == OFF_DST) begin
               dst_q[gi] <= pwdata;
            end else if (wr_here && reg_off == OFF_CNT) begin
               cnt_q[gi] <= pwdata;
            end else if (op_end) begin
               if (ctrl_q[gi][CTL_SRC_INC]) src_q[gi] <= src_q[gi] + step;
               if (ctrl_q[gi][CTL_DST_INC]) dst_q[gi] <= dst_q[gi] + step;
               cnt_q[gi] <= (cnt_q[gi] > step) ? cnt_q[gi] - step : 32'h0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Bandwidth window counter
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_q <= 10'h000;
      end else begin
         win_q <= win_q + 10'h001;
      end
   end

   // ------------------------------------------------------------
   // Arbiter: fixed priority, single owner
   // ------------------------------------------------------------
   assign grant[0] = want[0];
   assign grant[1] = want[1] & ~want[0];

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   logic [12:0] oc;
   logic [1:0] osz;
   logic bus_end;
   assign oc = ctrl_q[owner_q];
   assign osz = oc[CTL_SIZE_LO +: 2];
   // Any termination ends the cycle, error recorded
   assign bus_end = bus_rsp.done | bus_rsp.err;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         owner_q <= 1'b0;
         hold_q <= 17'h00000;
         last_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (|grant) begin
                  owner_q <= grant[1];
                  last_q <= 1'b0; // No stale completion on a new operand
                  state_q <= ST_READ;
               end
            end
            ST_READ: begin
               if (bus_end) begin
                  // Single-address is one cycle; dual goes on to write unless the read ended in error
                  hold_q <= {bus_rsp.err, (src_q[owner_q][1] ? bus_rsp.rdata[31:16] : bus_rsp.rdata[15:0])};
                  last_q <= (cnt_q[owner_q] <= {29'h0, osz == SZ_LONG, osz == SZ_WORD, osz == SZ_BYTE}) |
                            ext_done[owner_q];
                  state_q <= (oc[CTL_SINGLE] || bus_rsp.err) ? ST_FINISH : ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (bus_end) begin
                  hold_q[16] <= hold_q[16] | bus_rsp.err;
                  last_q <= last_q | ext_done[owner_q];
                  state_q <= ST_FINISH;
               end
            end
            ST_FINISH: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Bus request: dual path carries 16 bits, unpacked to lane by address
   logic [31:0] cur_addr;
   always_comb begin
      cur_addr = (state_q == ST_WRITE) ? dst_q[owner_q] : src_q[owner_q];
      if (oc[CTL_SINGLE]) begin
         cur_addr = oc[CTL_SA_WRITE] ? dst_q[owner_q] : src_q[owner_q];
      end
      bus_req.req = (state_q == ST_READ) | (state_q == ST_WRITE);
      bus_req.write = (state_q == ST_WRITE) | (oc[CTL_SINGLE] & oc[CTL_SA_WRITE]);
      bus_req.addr = cur_addr;
      bus_req.size = oc[CTL_SINGLE] ? osz : ((osz == SZ_LONG) ? SZ_WORD : osz);
      bus_req.wdata = oc[CTL_SINGLE] ? 32'h0 : (cur_addr[1] ? {hold_q[15:0], 16'h0} : {16'h0, hold_q[15:0]});
   end

   // Acknowledge during serviced cycle, source or destination side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (ctrl_q[owner_q][CTL_REQ_LO +: 2] != REQ_INT) &
                  ((state_q == ST_READ & ~ctrl_q[owner_q][CTL_ACK_DST]) |
                   (state_q == ST_WRITE & ctrl_q[owner_q][CTL_ACK_DST]) |
                   (state_q == ST_READ & ctrl_q[owner_q][CTL_SINGLE]));
      end
   end

   // Per-channel handshake pins; done driven only in external mode
   genvar gj;
   generate
      for (gj = 0; gj < NUM_CH; gj++) begin : g_pin
         logic drv_done;
         assign drv_done = ack_q & (owner_q == 1'(gj)) & last_q &
                           (ctrl_q[gj][CTL_REQ_LO +: 2] != REQ_INT);
         assign transfer_ack_n[gj] = ~(ack_q & (owner_q == 1'(gj)));
         assign done_n_out[gj] = 1'b0;
         assign done_n_oe_n[gj] = ~drv_done;
      end
   endgenerate

   // ------------------------------------------------------------
   // APB read data
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr & ~OFF_CH1)
            OFF_CTRL: prdata <= {19'h0, ctrl_q[ch_sel]};
            OFF_STAT: prdata <= {28'h0, stat_q[ch_sel]};
            OFF_SRC: prdata <= src_q[ch_sel];
            OFF_DST: prdata <= dst_q[ch_sel];
            OFF_CNT: prdata <= cnt_q[ch_sel];
            default: prdata <= 32'h0;
         endcase
      end
   end
endmodule

// ---- tb/tcd_mem_model.sv ----
// Memory bus partner of the transfer controller
// Assumes one request at a time on tcd_bus_req_t
module tcd_mem_model
   import tcd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire tcd_bus_req_t bus_req,
   input wire logic [1:0] wait_cyc,
   input wire logic [31:0] err_addr,
   output tcd_bus_rsp_t bus_rsp
);
   logic [1:0] cnt_q;
   // Answer after wait_cyc cycles; data toggles when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 2'h0;
         bus_rsp <= '0;
      end else begin
         bus_rsp.done <= 1'b0;
         bus_rsp.err <= 1'b0;
         bus_rsp.rdata <= ~bus_rsp.rdata;
         if (bus_req.req && !bus_rsp.done && !bus_rsp.err) begin
            if (cnt_q == wait_cyc) begin
               cnt_q <= 2'h0;
               bus_rsp.err <= bus_req.addr == err_addr;
               bus_rsp.done <= bus_req.addr != err_addr;
               bus_rsp.rdata <= bus_req.addr ^ 32'hA5A5_0000;
            end else begin
               cnt_q <= cnt_q + 2'h1;
            end
         end
      end
   end
endmodule

// ---- tb/tcd_dma_monitor.sv ----
// Port checker of the transfer controller
// Assumes binding onto every tcd_dma instance
module tcd_dma_monitor
   import tcd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire tcd_bus_req_t bus_req,
   input wire tcd_bus_rsp_t bus_rsp,
   input wire logic [1:0] transfer_request_n,
   input wire logic [1:0] transfer_ack_n,
   input wire logic [1:0] done_n_in,
   input wire logic [1:0] done_n_out,
   input wire logic [1:0] done_n_oe_n
);
   // ----
   // Port relations
   // ----
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_one_owner:
      assert property (transfer_ack_n != 2'h0) else $error("both channels acknowledged");
   chk_done_with_ack:
      assert property ((~done_n_oe_n & transfer_ack_n) == 2'h0) else $error("completion without ack");
   chk_done_level:
      assert property (done_n_oe_n != 2'h3 |-> done_n_out == 2'h0) else $error("completion not low");
   chk_req_holds:
      assert property (bus_req.req && !bus_rsp.done && !bus_rsp.err |=>
         bus_req.req && $stable(bus_req.addr) && $stable(bus_req.write)) else $error("bus request moved");
   chk_write_ends:
      assert property (bus_req.req && bus_req.write && bus_rsp.done |=> !bus_req.req)
      else $error("no idle after write");
   chk_read_then_write:
      assert property (bus_req.req && !bus_req.write && bus_rsp.done |=> !bus_req.req || bus_req.write)
      else $error("read not followed by write");
   chk_err_ends:
      assert property (bus_req.req && bus_rsp.err |=> !bus_req.req) else $error("bus error ignored");
   chk_apb_two_clk:
      assert property (psel && !penable |=> pready) else $error("register access slow");
   chk_apb_no_err:
      assert property (psel && penable |-> !pslverr) else $error("register error");
   cover property (!transfer_ack_n[0]);
   cover property (!transfer_ack_n[1]);
   cover property (bus_req.req && bus_rsp.err);
   cover property (done_n_oe_n != 2'h3);
endmodule
bind tcd_dma tcd_dma_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .bus_req(bus_req), .bus_rsp(bus_rsp), .transfer_request_n(transfer_request_n),
   .transfer_ack_n(transfer_ack_n), .done_n_in(done_n_in), .done_n_out(done_n_out),
   .done_n_oe_n(done_n_oe_n));

// ---- tb/test_two_channel_dma_controller.sv ----
// Self-checking bench of the two-channel transfer controller
// Assumes tcd_pkg, tcd_dma and tcd_mem_model
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] %s expected %h seen %h", n, e, a); end end
module test_two_channel_dma_controller
   import tcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Bench
   // ----
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic ack_seen = 1'b0, oe_seen = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, src, dst, err_addr = 32'hFFFF_FFFF;
   logic [1:0] req_n = 2'h3, ack_n, oe_n, wait_cyc = 2'h0, done_n = 2'h3;
   tcd_bus_req_t bus_req;
   tcd_bus_rsp_t bus_rsp;
   tcd_bus_req_t tr_q[$];
   int mismatches = 0, checks_done = 0;
   // Clock
   always #2 pclk = ~pclk;
   tcd_dma dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_req(bus_req), .bus_rsp(bus_rsp), .transfer_request_n(req_n), .transfer_ack_n(ack_n),
      .done_n_in(done_n), .done_n_out(), .done_n_oe_n(oe_n));
   tcd_mem_model mem (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .wait_cyc(wait_cyc),
      .err_addr(err_addr), .bus_rsp(bus_rsp));
   // Record finished bus cycles and handshake activity
   always @(posedge pclk) begin
      if (bus_req.req && (bus_rsp.done || bus_rsp.err)) tr_q.push_back(bus_req);
      if (ack_n != 2'h3) ack_seen <= 1'b1;
      if (oe_n != 2'h3) oe_seen <= 1'b1;
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] rq, bw, sz, input logic sa, oc);
      return 32'h1 | 32'(rq) << CTL_REQ_LO | 32'(bw) << CTL_BW_LO | 32'(sz) << CTL_SIZE_LO
         | 32'(sa) << CTL_SINGLE | 32'h3 << CTL_SRC_INC | 32'(oc) << CTL_ONCHIP;
   endfunction
   // Expected dual write word: source half of the memory answer moved to the destination lane
   function automatic logic [31:0] exp_wd(input logic [31:0] s, d);
      logic [15:0] h;
      h = s[1] ? (s[31:16] ^ 16'hA5A5) : s[15:0];
      return d[1] ? {h, 16'h0} : {16'h0, h};
   endfunction
   task automatic go(input int ch, input logic [31:0] c, n);
      logic [7:0] b;
      b = 8'(ch * CH_STRIDE);
      apb(1'b1, b + OFF_SRC, src);
      apb(1'b1, b + OFF_DST, dst);
      apb(1'b1, b + OFF_CNT, n);
      apb(1'b1, b + OFF_STAT, 32'hF);
      tr_q.delete();
      apb(1'b1, b + OFF_CTRL, c);
   endtask
   task automatic wait_st(input int ch, input logic [31:0] m);
      for (int i = 0; i < 3000; i++) begin
         apb(1'b0, 8'(ch * CH_STRIDE) + OFF_STAT, 32'h0);
         if ((rd & m) != 0) break;
      end
   endtask
   task automatic test_done();
      $display("Checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      test_done();
   end
   // Scenarios
   initial begin
      void'($urandom(32'h3C59D1AD));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("ack idle", 2'h3, ack_n)
      `CHK("done idle", 2'h3, oe_n)
      for (int ch = 0; ch < NUM_CH; ch++) begin
         for (int r = 2; r < 5; r++) begin
            src = $urandom();
            apb(1'b1, 8'(ch * CH_STRIDE + r * 4), src);
            apb(1'b0, 8'(ch * CH_STRIDE + r * 4), 32'h0);
            `CHK("pointer", src, rd)
         end
      end
      apb(1'b0, 8'h18, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      for (int sz = 0; sz < 3; sz++) begin
         src = $urandom() & 32'hFFFF_FF00;
         dst = src ^ 32'h0100_0000;
         wait_cyc <= 2'($urandom_range(0, 3));
         go(0, ctl(REQ_INT, 2'(sz), 2'(sz), 1'b0, 1'b0), 32'h8);
         wait_st(0, 32'h1);
         `CHK("dual status", 32'h1, rd)
         `CHK("first read", src, tr_q[0].addr)
         `CHK("then write", 2'b11, {tr_q[1].write, tr_q[1].addr == dst})
         `CHK("data path", 1'b1, tr_q[1].size <= SZ_WORD)
         `CHK("moved data", exp_wd(src, dst), tr_q[1].wdata)
         if (sz < 2) begin
            `CHK("next data", exp_wd(src + (32'h1 << sz), dst + (32'h1 << sz)), tr_q[3].wdata)
            `CHK("operands", 16 >> sz, tr_q.size())
            `CHK("next source", src + (32'h1 << sz), tr_q[2].addr)
         end
      end
      go(1, ctl(REQ_INT, 2'h0, SZ_LONG, 1'b1, 1'b0), 32'h8);
      wait_st(1, 32'h4);
      `CHK("internal single", 32'h4, rd)
      go(1, ctl(REQ_BURST, 2'h0, SZ_LONG, 1'b1, 1'b1), 32'h8);
      wait_st(1, 32'h4);
      `CHK("on-chip single", 32'h4, rd)
      go(1, ctl(REQ_BURST, 2'h0, SZ_LONG, 1'b1, 1'b0), 32'h8);
      repeat (5) @(posedge pclk);
      `CHK("waits for request", 0, tr_q.size())
      req_n[1] <= 1'b0;
      wait_st(1, 32'h1);
      req_n[1] <= 1'b1;
      `CHK("single cycles", 2, tr_q.size())
      `CHK("single size", SZ_LONG, tr_q[1].size)
      `CHK("single addr", src + 32'h4, tr_q[1].addr)
      `CHK("acknowledged", 1'b1, ack_seen)
      `CHK("completion", 1'b1, oe_seen)
      go(0, ctl(REQ_STEAL, 2'h0, SZ_BYTE, 1'b0, 1'b0), 32'h2);
      for (int p = 1; p < 3; p++) begin
         req_n[0] <= 1'b0;
         repeat (3) @(posedge pclk);
         req_n[0] <= 1'b1;
         repeat (40) @(posedge pclk);
         `CHK("one operand per pulse", 2 * p, tr_q.size())
      end
      wait_st(0, 32'h1);
      `CHK("steal status", 32'h1, rd)
      src = 32'h0000_1000;
      dst = 32'h0000_2000;
      go(0, ctl(REQ_BURST, 2'h0, SZ_BYTE, 1'b0, 1'b0), 32'h1);
      src = 32'h0000_3000;
      go(1, ctl(REQ_BURST, 2'h0, SZ_BYTE, 1'b0, 1'b0), 32'h1);
      req_n <= 2'h0;
      wait_st(1, 32'h1);
      req_n <= 2'h3;
      `CHK("channel 0 first", 32'h0000_1000, tr_q[0].addr)
      `CHK("channel 1 after", 32'h0000_3000, tr_q[2].addr)
      // Peer marks the first operand as final
      done_n <= 2'h2;
      go(0, ctl(REQ_INT, 2'h0, SZ_BYTE, 1'b0, 1'b0), 32'h8);
      wait_st(0, 32'h1);
      done_n <= 2'h3;
      `CHK("peer completion", 2, tr_q.size())
      err_addr <= dst;
      go(0, ctl(REQ_INT, 2'h0, SZ_WORD, 1'b0, 1'b0), 32'h4);
      wait_st(0, 32'h8);
      `CHK("bus error", 1'b1, rd[ST_BUS_ERR])
      `CHK("stopped", 2, tr_q.size())
      test_done();
   end
endmodule
